/* File: hdl/serial_port_consts.vh */
/*
 * constants for the serial port: apb offsets, control bits, mode codes, rates.
 * assumes core_clk at 100 MHz and word-aligned 32-bit apb access.
 */
`ifndef SERIAL_PORT_CONSTS_VH
`define SERIAL_PORT_CONSTS_VH

`define OFS_CONTROL 12'h000
`define OFS_DATA 12'h004
`define OFS_STATUS 12'h008
`define OFS_MASK 12'h00c
`define OFS_ADDR 12'h010
`define OFS_ADDRMASK 12'h014
`define OFS_RATE 12'h018

`define CTL_RXDONE 0
`define CTL_TXDONE 1
`define CTL_RXBIT8 2
`define CTL_TXBIT8 3
`define CTL_RXEN 4
`define CTL_MULTI 5
`define CTL_MODE_LO 6
`define CTL_MODE_HI 7

`define ST_TXDONE 0
`define ST_RXDONE 1
`define ST_OVERRUN 2
`define ST_FRAMEERR 3

`define MODE_SYNC 2'h0
`define MODE_ASYNC8 2'h1
`define MODE_FIXED9 2'h2
`define MODE_ASYNC9 2'h3

`define SYNC_DIV 16'h000c
`define FIXED_DIV_FAST 16'h0020
`define FIXED_DIV_SLOW 16'h0040
`define OVERSAMPLE 16'h0010
`define RATE_RESET 16'h0036

`endif

/* File: hdl/sync_two_ff.v */
/*
 * two-flop synchroniser for one level.
 * assumes din comes from outside the core_clk domain.
 */
`timescale 1ns/1ps
module sync_two_ff
#(
  parameter INIT = 1'b1
)
(
  input wire core_clk,
  input wire nrst,
  input wire din,
  output reg dout
);
  reg stage;

  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      stage <= INIT;
      dout <= INIT;
    end
    else
    begin
      stage <= din;
      dout <= stage;
    end
  end
endmodule

/* File: hdl/rate_divider.v */
/*
 * programmable divider giving a one-cycle enable pulse every period cycles.
 * assumes period is at least 1; a change applies at once to the count already running.
 */
`timescale 1ns/1ps
module rate_divider
(
  input wire core_clk,
  input wire nrst,
  input wire restart,
  input wire [15:0] period,
  output reg tick
);
  reg [15:0] count;

  always @(posedge core_clk)
  begin
    if (!nrst || restart)
    begin
      count <= 16'h0000;
      tick <= 1'b0;
    end
    else if (count >= period - 16'h0001)
    begin
      count <= 16'h0000;
      tick <= 1'b1;
    end
    else
    begin
      count <= count + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule

/* File: hdl/serial_port_zero.v */
/*
 * serial port with apb registers, four modes, receive holding register,
 * overrun and framing error, address match, sticky interrupts.
 * assumes an apb master on core_clk; line pins come from outside the domain.
 */
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ps
`include "serial_port_consts.vh"
// Notes on behaviour
// - software picks full-duplex async or half-duplex sync operation
// - finished received bytes go to a holding register; next reception continues
// - overrun bit set when a byte completes while the receive-done flag is still set; held byte is kept
// - one data address: read gives received byte, write loads transmitter
// - transmit-done flag, control bit 1, set when the stop bit starts (sync: after the last bit); interrupt source
// - receive-done flag, control bit 0, set when reception ends; interrupt source
// - hardware never clears the done flags; software must clear them
// - framing errors are detected and multiprocessor addresses recognised
// - four modes: sync at clock/12, async with 8 or 9 data bits
module serial_port_zero
(
  input wire core_clk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire rxPinIn,
  output reg rxPinOut,
  output reg rxPinOe,
  output reg txPin,
  output reg irq
);
  localparam TX_IDLE = 2'h0;
  localparam TX_SHIFT = 2'h1;
  localparam RX_IDLE = 2'h0;
  localparam RX_START = 2'h1;
  localparam RX_DATA = 2'h2;
  localparam RX_SYNC = 2'h3;

  reg [7:0] control;
  reg [7:0] rxHold;
  reg [3:0] status;
  reg [3:0] mask;
  reg [7:0] ownAddr;
  reg [7:0] addrMask;
  reg [15:0] rateDiv;
  reg smodFast;
  reg [1:0] txState;
  reg [10:0] txShift;
  reg [3:0] txBits;
  reg [3:0] txPhase;
  reg [1:0] rxState;
  reg [8:0] rxShift;
  reg [3:0] rxBits;
  reg [3:0] rxPhase;
  reg prevRx;
  wire rxLine;
  wire baudTick;
  wire syncTick;
  wire [1:0] mode = control[`CTL_MODE_HI:`CTL_MODE_LO];
  wire nineBit = mode[1];
  wire access = psel && penable;
  wire wrAcc = access && pwrite;
  wire dataWrite = wrAcc && paddr == `OFS_DATA;
  wire ctlWrite = wrAcc && paddr == `OFS_CONTROL;
  reg [15:0] next_period;
  reg txDoneEvt;
  reg rxDoneEvt;
  reg overrunEvt;
  reg frameEvt;

  sync_two_ff #(.INIT(1'b1)) rxSync (.core_clk(core_clk), .nrst(nrst), .din(rxPinIn),
    .dout(rxLine));

  // async modes oversample by 16; mode 2 rate fixed by the fast bit
  always @*
  begin
    next_period = rateDiv;
    if (mode == `MODE_FIXED9)
      next_period = (smodFast ? `FIXED_DIV_FAST : `FIXED_DIV_SLOW) / `OVERSAMPLE;
  end

  rate_divider baudGen (.core_clk(core_clk), .nrst(nrst), .restart(ctlWrite),
    .period(next_period), .tick(baudTick));
  // one tick per shift clock edge, so two ticks make one bit time
  rate_divider syncGen (.core_clk(core_clk), .nrst(nrst), .restart(1'b0),
    .period(`SYNC_DIV / 16'h0002), .tick(syncTick));

  // apb slave, zero wait states
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel && !penable && !pwrite)
      begin
        if (paddr == `OFS_CONTROL)
          prdata <= {24'h000000, control};
        else if (paddr == `OFS_DATA)
          prdata <= {24'h000000, rxHold};
        else if (paddr == `OFS_STATUS)
          prdata <= {28'h0000000, status};
        else if (paddr == `OFS_MASK)
          prdata <= {28'h0000000, mask};
        else if (paddr == `OFS_ADDR)
          prdata <= {24'h000000, ownAddr};
        else if (paddr == `OFS_ADDRMASK)
          prdata <= {24'h000000, addrMask};
        else if (paddr == `OFS_RATE)
          prdata <= {15'h0000, smodFast, rateDiv};
        else
          pslverr <= 1'b1;
      end
      else if (psel && !penable && pwrite && paddr != `OFS_CONTROL && paddr != `OFS_DATA
        && paddr != `OFS_STATUS && paddr != `OFS_MASK && paddr != `OFS_ADDR
        && paddr != `OFS_ADDRMASK && paddr != `OFS_RATE)
        pslverr <= 1'b1;
    end
  end

  // transmitter: sync mode shifts out on the data pin with clock on txPin
  always @(posedge core_clk)
  begin
    txDoneEvt <= 1'b0;
    if (!nrst)
    begin
      txState <= TX_IDLE;
      txShift <= 11'h7ff;
      txBits <= 4'h0;
      txPhase <= 4'h0;
      txPin <= 1'b1;
      rxPinOe <= 1'b1;
      rxPinOut <= 1'b1;
    end
    else
    begin
      case (txState)
        TX_IDLE:
        begin
          rxPinOe <= 1'b1;
          // sync reception borrows the shift clock from the idle transmitter
          if (rxState != RX_SYNC)
            txPin <= 1'b1;
          else if (syncTick)
            txPin <= ~txPin;
          if (dataWrite)
          begin
            txState <= TX_SHIFT;
            txPhase <= 4'h0;
            if (mode == `MODE_SYNC)
            begin
              txShift <= {3'h7, pwdata[7:0]};
              txBits <= 4'h8;
            end
            else
            begin
              // eight-bit frames must send a real stop bit, not the ninth bit
              txShift <= {1'b1, nineBit ? control[`CTL_TXBIT8] : 1'b1, pwdata[7:0], 1'b0};
              txBits <= nineBit ? 4'hb : 4'ha;
            end
          end
        end
        TX_SHIFT:
        begin
          if (mode == `MODE_SYNC)
          begin
            if (syncTick)
            begin
              // open drain: oe low drives the pin low only
              rxPinOe <= txShift[0];
              rxPinOut <= 1'b0;
              txPin <= ~txPin;
              if (txPin == 1'b0)
              begin
                txShift <= {1'b1, txShift[10:1]};
                txBits <= txBits - 4'h1;
                if (txBits == 4'h1)
                begin
                  txState <= TX_IDLE;
                  txDoneEvt <= 1'b1;
                end
              end
            end
          end
          else if (baudTick)
          begin
            txPin <= txShift[0];
            txPhase <= txPhase + 4'h1;
            if (txPhase == 4'hf)
            begin
              txShift <= {1'b1, txShift[10:1]};
              txBits <= txBits - 4'h1;
              // done marks start of stop bit, so flag at two bits left
              if (txBits == 4'h2)
                txDoneEvt <= 1'b1;
              if (txBits == 4'h1)
                txState <= TX_IDLE;
            end
          end
        end
        default:
          txState <= TX_IDLE;
      endcase
    end
  end

  // receiver with majority-free mid-bit sampling and address filter
  always @(posedge core_clk)
  begin
    rxDoneEvt <= 1'b0;
    overrunEvt <= 1'b0;
    frameEvt <= 1'b0;
    if (!nrst)
    begin
      rxState <= RX_IDLE;
      rxShift <= 9'h000;
      rxBits <= 4'h0;
      rxPhase <= 4'h0;
      prevRx <= 1'b1;
      rxHold <= 8'h00;
    end
    else
    begin
      if (baudTick)
        prevRx <= rxLine;
      case (rxState)
        RX_IDLE:
        begin
          rxPhase <= 4'h0;
          // flag lands a cycle after the event; do not restart in that gap
          if (control[`CTL_RXEN] && mode == `MODE_SYNC && !control[`CTL_RXDONE] && !rxDoneEvt
            && txState == TX_IDLE)
          begin
            rxState <= RX_SYNC;
            rxBits <= 4'h8;
          end
          else if (control[`CTL_RXEN] && mode != `MODE_SYNC && baudTick && prevRx && !rxLine)
          begin
            rxState <= RX_START;
            rxBits <= nineBit ? 4'h9 : 4'h8;
          end
        end
        RX_START:
          if (baudTick)
          begin
            rxPhase <= rxPhase + 4'h1;
            if (rxPhase == 4'h7)
            begin
              rxPhase <= 4'h0;
              rxState <= rxLine ? RX_IDLE : RX_DATA;
            end
          end
        RX_DATA:
          if (baudTick)
          begin
            rxPhase <= rxPhase + 4'h1;
            if (rxPhase == 4'hf)
            begin
              if (rxBits != 4'h0)
              begin
                rxShift <= {rxLine, rxShift[8:1]};
                rxBits <= rxBits - 4'h1;
              end
              else
              begin
                rxState <= RX_IDLE;
                if (!rxLine)
                  frameEvt <= 1'b1;
                // accepted frame lands in holding register
                if (!control[`CTL_RXDONE] && (!control[`CTL_MULTI] || (nineBit ?
                  (rxShift[8] && ((rxShift[7:0] ^ ownAddr) & addrMask) == 8'h00) : rxLine)))
                begin
                  rxHold <= nineBit ? rxShift[7:0] : rxShift[8:1];
                  rxDoneEvt <= 1'b1;
                end
                else if (control[`CTL_RXDONE])
                  overrunEvt <= 1'b1;
              end
            end
          end
        RX_SYNC:
          if (syncTick && txPin == 1'b0)
          begin
            rxShift <= {rxLine, rxShift[8:1]};
            rxBits <= rxBits - 4'h1;
            if (rxBits == 4'h1)
            begin
              rxState <= RX_IDLE;
              rxHold <= {rxLine, rxShift[8:2]};
              rxDoneEvt <= 1'b1;
            end
          end
        default:
          rxState <= RX_IDLE;
      endcase
    end
  end

  // control, flags and interrupt; hardware set wins over software clear
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      control <= 8'h00;
      status <= 4'h0;
      mask <= 4'h0;
      ownAddr <= 8'h00;
      addrMask <= 8'h00;
      rateDiv <= `RATE_RESET;
      smodFast <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      if (ctlWrite)
        control <= pwdata[7:0];
      if (txDoneEvt)
        control[`CTL_TXDONE] <= 1'b1;
      if (rxDoneEvt)
      begin
        control[`CTL_RXDONE] <= 1'b1;
        control[`CTL_RXBIT8] <= nineBit ? rxShift[8] : rxLine;
      end
      if (wrAcc && paddr == `OFS_MASK)
        mask <= pwdata[3:0];
      if (wrAcc && paddr == `OFS_ADDR)
        ownAddr <= pwdata[7:0];
      if (wrAcc && paddr == `OFS_ADDRMASK)
        addrMask <= pwdata[7:0];
      if (wrAcc && paddr == `OFS_RATE)
      begin
        rateDiv <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
        smodFast <= pwdata[16];
      end
      status <= (status & ~((wrAcc && paddr == `OFS_STATUS) ? pwdata[3:0] : 4'h0))
        | {frameEvt, overrunEvt, rxDoneEvt, txDoneEvt};
      irq <= |(status & mask);
    end
  end
endmodule

/* File: verification/serial_port_zero_properties.sv */
/* port checks for the serial port.
   assumes bind to serial_port_zero, reset synchronous active low. */
`timescale 1ns/1ps
module serial_port_zero_checker
(
  input wire core_clk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire rxPinIn,
  input wire rxPinOut,
  input wire rxPinOe,
  input wire txPin,
  input wire irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  property p_answer;
    psel && !penable |=> pready;
  endproperty
  a_answer: assert property (p_answer) else $error("no ready after setup");
  property p_one_beat;
    pready |=> !pready;
  endproperty
  a_one_beat: assert property (p_one_beat) else $error("ready held too long");
  property p_quiet_data;
    !pready |-> prdata == 32'h0;
  endproperty
  a_quiet_data: assert property (p_quiet_data) else $error("read data outside answer");
  property p_err_beat;
    pslverr |-> pready;
  endproperty
  a_err_beat: assert property (p_err_beat) else $error("error without ready");
  property p_idle;
    $rose(nrst) |-> !irq && txPin && rxPinOe && !pready;
  endproperty
  a_idle: assert property (p_idle) else $error("outputs not idle after reset");
  property p_drive_low;
    !rxPinOe |-> !rxPinOut;
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("open drain drives high");
  // only software writes may drop the interrupt
  property p_sticky;
    irq && !(psel && penable && pwrite) && !$past(psel && penable && pwrite) |=> irq;
  endproperty
  a_sticky: assert property (p_sticky) else $error("interrupt dropped by hardware");
  property p_no_spur;
    !psel ##1 !psel |-> !pready ##1 !pready;
  endproperty
  a_no_spur: assert property (p_no_spur) else $error("ready without request");
endmodule
bind serial_port_zero serial_port_zero_checker chk_i (.core_clk(core_clk), .nrst(nrst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxPinIn(rxPinIn),
  .rxPinOut(rxPinOut), .rxPinOe(rxPinOe), .txPin(txPin), .irq(irq));

/* File: verification/remote_serial.sv */
/* remote serial device on the data line.
   assumes a pull-up on the line; the port side may pull it low. */
`timescale 1ns/1ps
module remote_serial
(
  input wire core_clk,
  input wire shiftClk,
  input wire lineOut,
  input wire lineOe,
  output wire line
);
  reg drv = 1'b1;
  assign line = (!lineOe ? lineOut : 1'b1) & drv;
  // start, 8 data lsb first, stop; stop value lets a scenario break framing
  task send_byte(input [7:0] b, input stopVal);
    integer i;
    begin
      for (i = 0; i < 10; i = i + 1)
      begin
        drv <= (i == 0) ? 1'b0 : (i == 9) ? stopVal : b[i - 1];
        repeat (16) @(posedge core_clk);
      end
      drv <= 1'b1;
    end
  endtask
  // sync mode: new bit after each falling shift clock, released after the last rise
  task shift_reply(input [7:0] b);
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1)
      begin
        @(negedge shiftClk);
        drv <= b[i];
      end
      @(posedge shiftClk);
      drv <= 1'b1;
    end
  endtask
endmodule

/* File: verification/serial_port_zero_test.sv */
/* self-checking bench for the serial port.
   assumes divider 1, so 16 cycles per async bit; the mode 2 test runs at 32. */
`timescale 1ns/1ps
`include "serial_port_consts.vh"
module serial_port_zero_test;
  reg core_clk = 1'b0;
  reg nrst = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire pready, pslverr, rxPinIn, rxPinOut, rxPinOe, txPin, irq;
  reg [31:0] q;
  reg lastErr;
  integer err_count = 0;
  integer n_checks = 0;
  integer k;
  always #5 core_clk = ~core_clk;
  serial_port_zero serial_port_zero_i (.core_clk(core_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxPinIn(rxPinIn), .rxPinOut(rxPinOut),
    .rxPinOe(rxPinOe), .txPin(txPin), .irq(irq));
  remote_serial remote_serial_i (.core_clk(core_clk), .shiftClk(txPin), .lineOut(rxPinOut),
    .lineOe(rxPinOe), .line(rxPinIn));
  task apb(input wr, input [11:0] a, input [31:0] d);
    begin
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      k = 0;
      do
      begin
        @(posedge core_clk);
        k = k + 1;
      end
      while (pready !== 1'b1 && k < 50);
      if (pready !== 1'b1)
        err_count = err_count + 1;
      q = prdata;
      lastErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp)
      begin
        err_count = err_count + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task t_regs;
    begin
      apb(0, `OFS_STATUS, 0);
      chk(q, 32'h0);
      apb(0, 12'h01c, 0);
      chk(q, 32'h0);
      chk(lastErr, 1);
    end
  endtask
  task t_tx;
    integer i;
    begin
      apb(1, `OFS_RATE, 32'h1);
      apb(1, `OFS_CONTROL, 32'h50);
      apb(1, `OFS_MASK, 32'h1);
      apb(1, `OFS_DATA, 32'ha5);
      k = 0;
      while (txPin !== 1'b0 && k < 200)
      begin
        @(posedge core_clk);
        k = k + 1;
      end
      repeat (8) @(posedge core_clk);
      for (i = 0; i < 10; i = i + 1)
      begin
        chk(txPin, ({22'h0, 1'b1, 8'ha5, 1'b0} >> i) & 32'h1);
        repeat (16) @(posedge core_clk);
      end
      chk(irq, 1);
      repeat (300) @(posedge core_clk);
      apb(0, `OFS_CONTROL, 0);
      chk(q[1:0], 2'h2);
      apb(1, `OFS_STATUS, 32'h1);
      repeat (3) @(posedge core_clk);
      chk(irq, 0);
      apb(1, `OFS_CONTROL, 32'h50);
      apb(0, `OFS_CONTROL, 0);
      chk(q[1:0], 2'h0);
    end
  endtask
  task t_rx;
    begin
      remote_serial_i.send_byte(8'h3c, 1'b1);
      repeat (32) @(posedge core_clk);
      apb(0, `OFS_CONTROL, 0);
      chk(q[0], 1);
      remote_serial_i.send_byte(8'h77, 1'b1);
      repeat (32) @(posedge core_clk);
      apb(0, `OFS_STATUS, 0);
      chk(q & 32'h4, 32'h4);
      apb(1, `OFS_DATA, 32'h11);
      apb(0, `OFS_DATA, 0);
      chk(q, 32'h3c);
      repeat (200) @(posedge core_clk);
      apb(1, `OFS_STATUS, 32'hf);
      apb(1, `OFS_CONTROL, 32'h50);
      remote_serial_i.send_byte(8'h5a, 1'b0);
      repeat (32) @(posedge core_clk);
      apb(0, `OFS_STATUS, 0);
      chk(q & 32'h8, 32'h8);
    end
  endtask
  task t_nine;
    integer i;
    begin
      apb(1, `OFS_RATE, 32'h10001);
      apb(1, `OFS_CONTROL, 32'h88);
      apb(1, `OFS_DATA, 32'h3c);
      k = 0;
      while (txPin !== 1'b0 && k < 200)
      begin
        @(posedge core_clk);
        k = k + 1;
      end
      repeat (16) @(posedge core_clk);
      for (i = 0; i < 11; i = i + 1)
      begin
        chk(txPin, ({21'h0, 2'h3, 8'h3c, 1'b0} >> i) & 32'h1);
        repeat (32) @(posedge core_clk);
      end
    end
  endtask
  task t_sync;
    integer i;
    time t0;
    begin
      apb(1, `OFS_CONTROL, 32'h0);
      apb(1, `OFS_DATA, 32'h81);
      t0 = 0;
      for (i = 0; i < 8; i = i + 1)
      begin
        @(posedge txPin);
        if (i == 0)
          t0 = $time;
        chk(rxPinIn, (32'h81 >> i) & 32'h1);
      end
      chk(32'($time - t0), 32'd840);
      repeat (4) @(posedge core_clk);
      apb(0, `OFS_CONTROL, 0);
      chk(q[1:0], 2'h2);
      apb(1, `OFS_CONTROL, 32'h10);
      remote_serial_i.shift_reply(8'h96);
      repeat (4) @(posedge core_clk);
      apb(0, `OFS_DATA, 0);
      chk(q, 32'h96);
      apb(0, `OFS_CONTROL, 0);
      chk(q[0], 1);
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_count = err_count + 1;
    give_verdict;
  end
  initial
  begin
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    t_regs;
    t_tx;
    t_rx;
    t_nine;
    t_sync;
    give_verdict;
  end
endmodule
